/* hw/dmc_channel.sv */
// dma channel a: mode control, counting and bus sequencing.
// assumes apb master, internal bus with ack, events as one-cycle pulses.
//
// Added by the designer: the register addresses and the APB interface to the registers.
module dmc_channel
  import dmc_pkg::*;
(
  input  wire logic        i_clk,        // 250 MHz system clock
  input  wire logic        i_reset_n,    // async reset, active low
  input  wire logic        i_ce,         // clock enable, freezes state
  input  wire logic        i_standby,    // standby entry, clears control
  input  wire logic        i_psel,       // apb select
  input  wire logic        i_penable,    // apb access phase
  input  wire logic        i_pwrite,     // apb direction
  input  wire logic [7:0]  i_paddr,      // apb byte address
  input  wire logic [31:0] i_pwdata,     // apb write data
  output logic      [31:0] o_prdata,     // apb read data
  output logic             o_pready,     // apb ready
  output logic             o_pslverr,    // apb error, unmapped
  input  wire logic        i_adc_end,    // converter end pulse
  input  wire logic [3:0]  i_sci_evt,    // serial tx0 rx0 tx1 rx1
  input  wire logic [5:0]  i_tpu_evt,    // timer ch 0..5 match a
  output logic             o_bus_req,    // internal bus request
  output logic      [23:0] o_bus_addr,   // bus address
  output logic             o_bus_write,  // bus write
  output logic             o_bus_word,   // word access
  output logic      [15:0] o_bus_wdata,  // bus write data
  input  wire logic        i_bus_ack,    // bus cycle complete
  input  wire logic [15:0] i_bus_rdata,  // bus read data
  output logic             o_dma_ack_strobe, // single mode strobe
  output logic             o_irq,        // level interrupt
  output logic             o_channel_active // channel enable set
);

  // ----------------------------------------------------------
  // state types
  // ----------------------------------------------------------
  // control state, reset to constants
  typedef struct packed {
    dmc_state_e  state;   // sequencer
    logic        pend;    // activation pending
    logic        stat;    // sticky end event
    logic        mask;    // interrupt mask
    logic [7:0]  ctrl;    // channel_control_reg
    logic [2:0]  band;    // band_control_reg subset
    logic [15:0] data;    // transfer data latch
    logic        req;     // bus request
    logic [23:0] addr;    // bus address
    logic        wr;      // bus write
    logic        word;    // bus size
    logic [15:0] wdata;   // bus write data
    logic        dma_ack_strobe;    // acknowledge strobe
    logic        pready;  // apb ready
    logic [31:0] prdata;  // apb read data
    logic        pslverr; // apb error
    logic        irq;     // interrupt
    logic        act;     // channel active
  } dmc_ctl_s;

  // address and count state, never reset
  typedef struct packed {
    logic [23:0] memory_address_reg;     // memory_address_reg
    logic [23:0] start;   // address at count start
    logic [15:0] io_address_reg;    // io_address_reg
    logic [15:0] count;   // transfer_count_reg
  } dmc_keep_s;

  dmc_ctl_s  r;       // control registers
  dmc_ctl_s  next_r;  // next control
  dmc_keep_s k;       // retained registers
  dmc_keep_s next_k;  // next retained

  // ----------------------------------------------------------
  // functions
  // ----------------------------------------------------------
  // mode from repeat select and interrupt enable
  function automatic dmc_mode_e mode_of(input logic rpt, input logic ie);
    if (!rpt) begin
      return MODE_SEQ;
    end
    return ie ? MODE_HOLD : MODE_RPT;
  endfunction

  // selected activation source fired
  function automatic logic src_hit(input logic [3:0] code,
                                   input logic adc,
                                   input logic [3:0] serial_comm_unit,
                                   input logic [5:0] timer_pulse_unit);
    logic [3:0] ofs;
    ofs = 4'h0;
    if (code == SRC_ADC) begin
      return adc;
    end
    if (code >= SRC_SCI0 && code <= SRC_SCI3) begin
      ofs = code - SRC_SCI0;
      return serial_comm_unit[ofs[1:0]];
    end
    if (code >= SRC_TPU0 && code <= SRC_TPU5) begin
      ofs = code - SRC_TPU0;
      return timer_pulse_unit[ofs[2:0]];
    end
    return 1'b0; // zero and unused codes
  endfunction

  // next memory address after one transfer
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                            input logic word,
                                            input logic dec);
    logic [23:0] s;
    s = word ? 24'h000002 : 24'h000001;
    return dec ? a - s : a + s;
  endfunction

  // ----------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------
  logic        setup;   // apb setup phase
  logic        wr_acc;  // apb write takes effect
  logic        hit;     // decoded address mapped
  logic        done;    // transfer finished
  logic        ev_end;  // transfer end event
  logic [7:0]  low;     // decremented repeat counter
  logic [23:0] io_full; // full io address
  logic [31:0] rd;      // read mux
  dmc_mode_e   mode;    // current mode

  always_comb begin
    next_r  = r;
    next_k  = k;
    done    = 1'b0;
    ev_end  = 1'b0;
    low     = k.count[7:0] - 8'h01;
    io_full = {IO_UPPER, k.io_address_reg};
    mode    = mode_of(r.ctrl[CTRL_RPT], r.band[BAND_IE]);
    setup   = i_psel && !i_penable;
    wr_acc  = i_psel && i_penable && r.pready && i_pwrite;
    hit     = (i_paddr == OFS_MAR) || (i_paddr == OFS_IO_ADDRESS_REG) ||
              (i_paddr == OFS_COUNT) || (i_paddr == OFS_CTRL) ||
              (i_paddr == OFS_BAND) || (i_paddr == OFS_STAT) ||
              (i_paddr == OFS_MASK);
    // read mux, unmapped reads as zero
    unique case (i_paddr)
      OFS_MAR:   rd = {8'h00, k.memory_address_reg};
      OFS_IO_ADDRESS_REG:  rd = {16'h0000, k.io_address_reg};
      OFS_COUNT: rd = {16'h0000, k.count};
      OFS_CTRL:  rd = {24'h000000, r.ctrl};
      OFS_BAND:  rd = {29'h00000000, r.band};
      OFS_STAT:  rd = {31'h00000000, r.stat};
      OFS_MASK:  rd = {31'h00000000, r.mask};
      default:   rd = 32'h00000000;
    endcase

    // activation latch, only while enabled
    if (r.band[BAND_EN] &&
        src_hit(r.ctrl[3:0], i_adc_end, i_sci_evt, i_tpu_evt)) begin
      next_r.pend = 1'b1;
    end

    // sequencer
    unique case (r.state)
      ST_IDLE: begin
        if (r.band[BAND_EN] && r.pend) begin
          next_r.pend  = 1'b0;
          next_r.state = r.band[BAND_SAE] ? ST_SINGLE : ST_READ;
        end
      end
      ST_READ: begin
        // dual mode read phase
        if (i_bus_ack) begin
          next_r.data  = i_bus_rdata;
          next_r.state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        // dual mode write phase
        if (i_bus_ack) begin
          done         = 1'b1;
          next_r.state = ST_IDLE;
        end
      end
      ST_SINGLE: begin
        // one cycle with acknowledge strobe
        if (i_bus_ack) begin
          done         = 1'b1;
          next_r.state = ST_IDLE;
        end
      end
    endcase

    // address and count update per transfer
    if (done) begin
      if (mode != MODE_HOLD) begin
        next_k.memory_address_reg = step_addr(k.memory_address_reg, r.ctrl[CTRL_SIZE],
                               r.ctrl[CTRL_STEP]);
      end else begin
        next_k.memory_address_reg = k.memory_address_reg;
      end
      if (mode == MODE_RPT) begin
        // enable stays set in repeat
        if (low == CNT_ZERO) begin
          next_k.count[7:0] = k.count[15:8];
          next_k.memory_address_reg        = k.start;
        end else begin
          next_k.count[7:0] = low;
        end
      end else begin
        next_k.count = k.count - 16'h0001;
        if (k.count == 16'h0001) begin
          next_r.band[BAND_EN] = 1'b0;
          next_r.pend          = 1'b0;
          ev_end               = r.band[BAND_IE];
        end
      end
    end

    // apb writes
    if (wr_acc) begin
      unique case (i_paddr)
        OFS_MAR: begin
          next_k.memory_address_reg   = i_pwdata[23:0];
          next_k.start = i_pwdata[23:0];
        end
        OFS_IO_ADDRESS_REG:  next_k.io_address_reg  = i_pwdata[15:0];
        OFS_COUNT: next_k.count = i_pwdata[15:0];
        OFS_CTRL:  next_r.ctrl  = i_pwdata[7:0];
        OFS_BAND: begin
          next_r.band = i_pwdata[2:0];
          // capture address for repeat restore
          if (i_pwdata[BAND_EN] && !r.band[BAND_EN]) begin
            next_k.start = next_k.memory_address_reg;
          end
          if (!i_pwdata[BAND_EN]) begin
            next_r.pend = 1'b0;
          end
        end
        OFS_STAT: next_r.stat = r.stat & ~i_pwdata[STAT_END];
        OFS_MASK: next_r.mask = i_pwdata[STAT_END];
        default: begin
        end
      endcase
    end

    // event set wins over write-one clear
    if (ev_end) begin
      next_r.stat = 1'b1;
    end

    // standby: clear control, abort, keep addresses and count
    if (i_standby) begin
      next_r.ctrl  = CTRL_RESET;
      next_r.band  = BAND_RESET;
      next_r.pend  = 1'b0;
      next_r.state = ST_IDLE;
    end

    // apb answer, one access cycle after setup
    next_r.pready  = setup;
    next_r.prdata  = setup ? rd : 32'h00000000;
    next_r.pslverr = setup && !hit;

    // bus outputs from next state
    next_r.req   = (next_r.state != ST_IDLE);
    next_r.word  = next_r.ctrl[CTRL_SIZE];
    next_r.wdata = next_r.data;
    next_r.dma_ack_strobe  = (next_r.state == ST_SINGLE);
    next_r.addr  = 24'h000000;
    next_r.wr    = 1'b0;
    unique case (next_r.state)
      ST_READ: begin
        // source per direction
        next_r.addr = next_r.ctrl[CTRL_DIR] ? io_full : next_k.memory_address_reg;
      end
      ST_WRITE: begin
        // destination per direction
        next_r.addr = next_r.ctrl[CTRL_DIR] ? next_k.memory_address_reg : io_full;
        next_r.wr   = 1'b1;
      end
      ST_SINGLE: begin
        // memory side; strobe plays the other end
        next_r.addr = next_k.memory_address_reg;
        next_r.wr   = next_r.ctrl[CTRL_DIR];
      end
      default: begin
      end
    endcase
    next_r.irq = next_r.stat && next_r.mask;
    next_r.act = next_r.band[BAND_EN];
  end

  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  // async reset to constants, frozen while ce low
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r         <= '0;
      r.state   <= ST_IDLE;
      r.ctrl    <= CTRL_RESET;
      r.band    <= BAND_RESET;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------
  // retained registers
  // ----------------------------------------------------------
  // no reset: contents survive reset and standby
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      k <= next_k;
    end
  end

  // ----------------------------------------------------------
  // outputs straight from flops
  // ----------------------------------------------------------
  assign o_prdata         = r.prdata;
  assign o_pready         = r.pready;
  assign o_pslverr        = r.pslverr;
  assign o_bus_req        = r.req;
  assign o_bus_addr       = r.addr;
  assign o_bus_write      = r.wr;
  assign o_bus_word       = r.word;
  assign o_bus_wdata      = r.wdata;
  assign o_dma_ack_strobe = r.dma_ack_strobe;
  assign o_irq            = r.irq;
  assign o_channel_active = r.act;

endmodule

/* inc/dmc_pkg.sv */
// dma channel mode control: shared constants, types and register map.
// assumes one system clock and an apb register port.
package dmc_pkg;
  // ----------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------
  localparam logic [7:0] OFS_MAR   = 8'h00; // memory address
  localparam logic [7:0] OFS_IO_ADDRESS_REG  = 8'h04; // io address
  localparam logic [7:0] OFS_COUNT = 8'h08; // transfer count
  localparam logic [7:0] OFS_CTRL  = 8'h0C; // channel control
  localparam logic [7:0] OFS_BAND  = 8'h10; // enable, int enable, single
  localparam logic [7:0] OFS_STAT  = 8'h14; // sticky events
  localparam logic [7:0] OFS_MASK  = 8'h18; // interrupt mask
  // ----------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------
  localparam int CTRL_SIZE = 7; // word when set
  localparam int CTRL_STEP = 6; // decrement when set
  localparam int CTRL_RPT  = 5; // repeat select
  localparam int CTRL_DIR  = 4; // direction select
  localparam int BAND_EN   = 0; // channel enable
  localparam int BAND_IE   = 1; // end interrupt enable
  localparam int BAND_SAE  = 2; // single address select
  localparam int STAT_END  = 0; // transfer end event
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] BAND_RESET = 3'h0;
  localparam logic [7:0] IO_UPPER   = 8'hFF;
  localparam logic [7:0] CNT_ZERO   = 8'h00;
  // activation source codes
  localparam logic [3:0] SRC_ADC   = 4'h1;
  localparam logic [3:0] SRC_SCI0  = 4'h4;
  localparam logic [3:0] SRC_SCI3  = 4'h7;
  localparam logic [3:0] SRC_TPU0  = 4'h8;
  localparam logic [3:0] SRC_TPU5  = 4'hD;
  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_SINGLE} dmc_state_e;
  typedef enum logic [1:0] {MODE_SEQ, MODE_RPT, MODE_HOLD} dmc_mode_e;
endpackage

/* sim/dmc_bus_model.sv */
// partner: memory and peripherals on the internal bus.
// assumes the request holds until ack; i_delay sets the wait cycles.
module dmc_bus_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_req,
  input  wire logic [23:0] i_addr,
  output logic             o_ack,
  output logic      [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waited; // cycles the request has waited
  // ack after i_delay cycles; read data follows the address
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ack   <= 1'b0;
      o_rdata <= 16'h0000;
      waited  <= 4'h0;
    end else if (i_req && !o_ack && waited >= i_delay) begin
      o_ack   <= 1'b1;
      o_rdata <= i_addr[15:0] ^ 16'h5A5A;
      waited  <= 4'h0;
    end else begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata; // not valid outside ack
      waited  <= (i_req && !o_ack) ? waited + 4'h1 : 4'h0;
    end
  end
endmodule

/* sim/dmc_channel_properties.sv */
// checker: apb and internal bus timing of the dma channel.
// assumes it is bound into dmc_channel; one clock domain.
module dmc_channel_properties (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_ce,
  input wire logic        i_standby,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_bus_req,
  input wire logic [23:0] o_bus_addr,
  input wire logic        o_bus_write,
  input wire logic [15:0] o_bus_wdata,
  input wire logic        i_bus_ack,
  input wire logic [15:0] i_bus_rdata,
  input wire logic        o_dma_ack_strobe,
  input wire logic        o_channel_active
);
  logic [15:0] last_rd; // data taken in any acked bus read cycle
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ----------------------------------------------------------
  // helper
  // ----------------------------------------------------------
  // remember read data for the write phase compare
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      last_rd <= 16'h0000;
    else if (o_bus_req && i_bus_ack && !o_bus_write)
      last_rd <= i_bus_rdata;
  end
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  a_ready_setup: assert property (i_psel && !i_penable && i_ce |=> o_pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (o_pready && i_ce |=> !o_pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (i_psel && !i_penable && i_ce && i_paddr > 8'h18 |=> o_pslverr)
    else $error("unmapped access without error");
  a_err_zero_data: assert property (o_pslverr |-> o_prdata == 32'h0000_0000)
    else $error("error read data not zero");
  a_req_holds: assert property (o_bus_req && !i_bus_ack && !i_standby
    |=> o_bus_req && $stable(o_bus_addr) && $stable(o_bus_write))
    else $error("bus request dropped or changed");
  a_dual_wdata: assert property (o_bus_req && o_bus_write && !o_dma_ack_strobe
    |-> o_bus_wdata == last_rd) else $error("write data differs from read");
  a_strobe_in_cycle: assert property (o_dma_ack_strobe |-> o_bus_req)
    else $error("strobe outside bus cycle");
  a_standby_stop: assert property (i_standby && i_ce |=> !o_channel_active)
    else $error("channel active after standby");
  c_single: cover property (o_dma_ack_strobe && i_bus_ack);
  c_dual: cover property (o_bus_write && i_bus_ack && !o_dma_ack_strobe);
  c_error: cover property (o_pslverr);
endmodule

/* sim/testbench.sv */
// testbench: apb driver and scenarios for the dma channel.
// assumes dmc_channel, dmc_bus_model and the checker are compiled.
module testbench import dmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, standby, psel, penable, pwrite, pready, pslverr, ce;
  logic bus_req, bus_write, bus_word, bus_ack, dma_ack_strobe, irq, active, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [10:0] ev; // adc, serial 0..3, timer 0..5
  logic [23:0] bus_addr, last_ra;
  logic [15:0] bus_wdata, bus_rdata;
  logic [3:0]  delay;
  int n_errors, checks;
  always #2 clk = ~clk;
  dmc_channel i_dut (.i_clk(clk), .i_reset_n(reset_n), .i_ce(ce), .i_standby(standby),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_adc_end(ev[0]), .i_sci_evt(ev[4:1]), .i_tpu_evt(ev[10:5]), .o_bus_req(bus_req),
    .o_bus_addr(bus_addr), .o_bus_write(bus_write), .o_bus_word(bus_word),
    .o_bus_wdata(bus_wdata), .i_bus_ack(bus_ack), .i_bus_rdata(bus_rdata),
    .o_dma_ack_strobe(dma_ack_strobe), .o_irq(irq), .o_channel_active(active));
  dmc_bus_model i_mem (.i_clk(clk), .i_reset_n(reset_n), .i_delay(delay), .i_req(bus_req),
    .i_addr(bus_addr), .o_ack(bus_ack), .o_rdata(bus_rdata));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic timeout;
    n_errors++;
    $display("mismatch at %0t: wait ran out, seen %h expected %h", $time, 1'b0, 1'b1);
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, waits for pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout();
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [10:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 11'h000;
    @(posedge clk);
  endtask
  // wait for an acked bus cycle and judge it
  task automatic bus_cyc(input logic [23:0] a, input logic w, input logic s);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(bus_req === 1'b1 && bus_ack === 1'b1) && n < 40);
    if (!(bus_req === 1'b1 && bus_ack === 1'b1)) timeout();
    chk(bus_addr, a);
    chk(bus_write, w);
    chk(dma_ack_strobe, s);
    if (!w) last_ra = a;
    if (w && !s) chk(bus_wdata, last_ra[15:0] ^ 16'h5A5A);
    @(posedge clk);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (active !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (active !== 1'b0) timeout();
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [10:0] onehot(input logic [3:0] c);
    if (c == 4'h1) return 11'h001;
    if (c >= 4'h4 && c <= 4'hD) return 11'h001 << (c - 4'h3);
    return 11'h000;
  endfunction
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    rd(OFS_CTRL); chk(rv, 32'h0);
    wr(OFS_CTRL, 32'hFF); rd(OFS_CTRL); chk(rv, 32'hFF);
    // standby seen while clock enable is low must not clear anything
    ce <= 1'b0;
    standby <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    standby <= 1'b0;
    @(posedge clk);
    rd(OFS_CTRL); chk(rv, 32'hFF);
    wr(OFS_COUNT, 32'h1234);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    @(posedge clk);
    rd(OFS_CTRL); chk(rv, 32'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(OFS_COUNT); chk(rv, 32'h1234);
    rd(8'h1C); chk(err, 1'b1); chk(rv, 32'h0);
    $display("registers done");
  endtask
  task automatic t_seq;
    wr(OFS_MAR, 32'h1000); wr(OFS_IO_ADDRESS_REG, 32'h2000); wr(OFS_COUNT, 32'h2);
    wr(OFS_CTRL, {28'h0, SRC_ADC}); wr(OFS_MASK, 32'h1); wr(OFS_BAND, 32'h3);
    for (int i = 0; i < 2; i++) begin
      pulse(11'h001);
      bus_cyc(24'h001000 + 24'(i), 1'b0, 1'b0);
      chk(bus_word, 1'b0);
      bus_cyc(24'hFF2000, 1'b1, 1'b0);
    end
    wait_idle();
    chk(irq, 1'b1);
    rd(OFS_MAR); chk(rv, 32'h1002);
    wr(OFS_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("sequential done");
  endtask
  task automatic t_rpt;
    delay <= 4'h3;
    wr(OFS_MAR, 32'h1000); wr(OFS_IO_ADDRESS_REG, 32'h3000); wr(OFS_COUNT, 32'h0202);
    wr(OFS_CTRL, 32'hF4); wr(OFS_BAND, 32'h1);
    for (int i = 0; i < 3; i++) begin
      pulse(11'h002);
      bus_cyc(24'hFF3000, 1'b0, 1'b0);
      chk(bus_word, 1'b1);
      bus_cyc(i == 1 ? 24'h000FFE : 24'h001000, 1'b1, 1'b0);
    end
    chk(active, 1'b1);
    rd(OFS_COUNT); chk(rv, 32'h0201);
    wr(OFS_BAND, 32'h0);
    delay <= 4'h0;
    $display("repeat done");
  endtask
  task automatic t_idle;
    wr(OFS_MAR, 32'h0500);
    for (int d = 0; d < 2; d++) begin
      wr(OFS_COUNT, 32'h1); wr(OFS_CTRL, 32'h28 | (d << 4)); wr(OFS_BAND, 32'h7);
      pulse(11'h020);
      bus_cyc(24'h000500, d[0], 1'b1);
      wait_idle();
    end
    rd(OFS_MAR); chk(rv, 32'h0500);
    wr(OFS_STAT, 32'h1);
    $display("idle single done");
  endtask
  task automatic t_src;
    logic [10:0] oh;
    logic        got;
    for (int c = 0; c < 16; c++) begin
      oh = onehot(c[3:0]);
      wr(OFS_COUNT, 32'h1); wr(OFS_CTRL, {28'h0, c[3:0]}); wr(OFS_BAND, 32'h1);
      for (int k = 0; k < 2; k++) begin
        pulse(k == 0 ? ~oh : oh);
        got = 1'b0;
        repeat (12) begin
          @(negedge clk);
          if (bus_req === 1'b1) got = 1'b1;
        end
        @(posedge clk);
        chk(got, k == 1 && oh != 11'h0);
      end
      wr(OFS_BAND, 32'h0);
    end
    $display("sources done");
  endtask
  initial begin
    {clk, standby, psel, penable, pwrite, reset_n} = '0;
    {paddr, pwdata, ev, delay, last_ra} = '0;
    ce = 1'b1;
    n_errors = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_seq();
    t_rpt();
    t_idle();
    t_src();
    end_of_test();
  end
endmodule
bind dmc_channel dmc_channel_properties u_props (.i_clk, .i_reset_n, .i_ce, .i_standby,
  .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_bus_req, .o_bus_addr,
  .o_bus_write, .o_bus_wdata, .i_bus_ack, .i_bus_rdata, .o_dma_ack_strobe, .o_channel_active);
